/* common/pib_consts.vh */
`ifndef PIB_CONSTS_VH
`define PIB_CONSTS_VH
// Configuration offsets
`define PIB_OFS_FC2        8'h41
`define PIB_OFS_FC3        8'h42
`define PIB_OFS_FC4        8'h43
`define PIB_OFS_RSTCTL     8'h44
`define PIB_OFS_ISACLK     8'h50
`define PIB_OFS_IOREC      8'h51
`define PIB_OFS_ROMCTL     8'h52
`define PIB_OFS_DECCTL2    8'h5B
// Reset values
`define PIB_RST_FC2        8'h10
`define PIB_RST_FC3        8'h28
`define PIB_RST_FC4        8'h46
`define PIB_RST_ISACLK     8'h43
`define PIB_RST_IOREC      8'h43
`define PIB_RST_ROMCTL     8'h04
`define PIB_RST_DECCTL2    8'h00
// Field positions
`define PIB_BIT_PERR_SERR  5
`define PIB_BIT_WBUF       4
`define PIB_BIT_SUBD_HI    2
`define PIB_BIT_SUBD_LO    1
`define PIB_BIT_DELAYED    5
`define PIB_BIT_NOARB      3
`define PIB_BIT_RETRY      1
`define PIB_BIT_WARM       0
`define PIB_BIT_ROMCLAIM   5
// Writable masks: reserved bits forced to zero
`define PIB_MASK_FC4       8'h7F
`define PIB_MASK_DECCTL2   8'hBF
// Subtractive sample points, clocks after frame start
`define PIB_SAMPLE_DEFAULT 3'h4
`define PIB_SAMPLE_EARLY   3'h3
// ISA divisor codes
`define PIB_DIV3           3'h2
`define PIB_DIV4           3'h3
// Warm start pulse length in clocks
`define PIB_WARM_CYCLES    4'hF
`endif

/* src/pib_isa_timing.v */
`timescale 1ns/100ps
`include "pib_consts.vh"
module pib_isa_timing (
    input  wire       clk_sys,
    input  wire       rstSync_n,
    input  wire [2:0] clkDivCode,
    input  wire [3:0] rec8,
    input  wire [3:0] rec16,
    input  wire       ioDone,
    input  wire       ioIs16,
    output reg        isaClk,
    output reg        ioHold
);
    reg [1:0] divCnt;   // PCI clock count within ISA period
    reg [4:0] recCnt;   // Recovery clocks left
    wire [1:0] divLast; // Last count of the period
    // Divide by four for code 011, three otherwise; bad codes are the
    // software's fault, this only keeps the clock alive
    assign divLast = (clkDivCode == `PIB_DIV4) ? 2'h3 : 2'h2;

    // ISA clock divider, high for the first two clocks of four, or the first clock of three
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            divCnt <= 2'h0;
            isaClk <= 1'b0;
        end else begin
            divCnt <= (divCnt >= divLast) ? 2'h0 : divCnt + 2'h1;
            isaClk <= (divCnt < 2'h1) || (divLast == 2'h3 && divCnt == 2'h1);
        end
    end

    // Recovery: code plus one, plus the built-in clock
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            recCnt <= 5'h0;
            ioHold <= 1'b0;
        end else if (ioDone) begin
            // Load on cycle end; hold covers the whole gap
            recCnt <= ioIs16 ? {1'b0, rec16} + 5'h1
                             : {1'b0, rec8} + 5'h1;
            ioHold <= 1'b1;
        end else if (recCnt != 5'h0) begin
            recCnt <= recCnt - 5'h1;
            ioHold <= 1'b1;
        end else begin
            ioHold <= 1'b0;
        end
    end
endmodule

/* src/pib_config_regs.v */
`timescale 1ns/100ps
`include "pib_consts.vh"
module pib_config_regs (
    input  wire       clk_sys,
    input  wire       rst_n,
    input  wire       cfgWrite,
    input  wire       cfgRead,
    input  wire [7:0] cfgAddr,
    input  wire [7:0] cfgWdata,
    output reg  [7:0] cfgRdata,
    input  wire       frameStart_n,
    input  wire       devselSeen_n,
    input  wire       romHit,
    input  wire       perrSeen_n,
    input  wire       perrDriven,
    input  wire       bufFull,
    input  wire       ioDone,
    input  wire       ioIs16,
    output reg        serrOut_n,
    output reg        serrOe,
    output reg        subClaim,
    output reg        romClaim,
    output reg        wbufEn,
    output reg        delayedEn,
    output reg        noArbBuf,
    output reg        retryReq,
    output reg        warmReset,
    output reg        isaClk,
    output reg        ioHold
);
    reg [1:0] rstSync;          // Reset release synchroniser
    wire      rstSync_n;        // Synchronised reset
    reg [7:0] fc2;              // Function control two
    reg [7:0] fc3;              // Function control three
    reg [7:0] fc4;              // Function control four
    reg [7:0] isaDiv;           // ISA clock divider
    reg [7:0] ioRec;            // I/O recovery counts
    reg [7:0] romCtl;           // ROM control
    reg [7:0] decCtl2;          // Decode control two
    reg [1:0] frameMeta;        // Pin synchronisers
    reg [1:0] devMeta;
    reg [1:0] perrMeta;
    reg       frameS_n;         // Second stages
    reg       devS_n;
    reg       perrS_n;
    reg       frameLast_n;      // Edge detect on synced frame
    reg [2:0] frameClk;         // Clocks since frame start
    reg       tracking;         // Frame being watched
    reg       devClaimed;       // Another agent or the ROM claim answered
    reg [3:0] warmCnt;          // Warm reset pulse length
    wire      isaClkInt;
    wire      ioHoldInt;
    wire [2:0] samplePoint;

    // Reset asserts at once and releases after two edges
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            rstSync <= 2'b00;
        else
            rstSync <= {rstSync[0], 1'b1};
    end
    assign rstSync_n = rstSync[1];

    // Two-flop synchronisers for bus pins; only stage two is read
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            frameMeta <= 2'b11;
            devMeta   <= 2'b11;
            perrMeta  <= 2'b11;
        end else begin
            frameMeta <= {frameMeta[0], frameStart_n};
            devMeta   <= {devMeta[0], devselSeen_n};
            perrMeta  <= {perrMeta[0], perrSeen_n};
        end
    end
    always @* begin
        frameS_n = frameMeta[1];
        devS_n   = devMeta[1];
        perrS_n  = perrMeta[1];
    end

    // Configuration writes; reserved bits are masked to zero
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            fc2     <= `PIB_RST_FC2;
            fc3     <= `PIB_RST_FC3;
            fc4     <= `PIB_RST_FC4;
            isaDiv  <= `PIB_RST_ISACLK;
            ioRec   <= `PIB_RST_IOREC;
            romCtl  <= `PIB_RST_ROMCTL;
            decCtl2 <= `PIB_RST_DECCTL2;
        end else if (cfgWrite) begin
            case (cfgAddr)
                `PIB_OFS_FC2:     fc2     <= cfgWdata;
                `PIB_OFS_FC3:     fc3     <= cfgWdata;
                `PIB_OFS_FC4:     fc4     <= cfgWdata & `PIB_MASK_FC4;
                `PIB_OFS_ISACLK:  isaDiv  <= cfgWdata;
                `PIB_OFS_IOREC:   ioRec   <= cfgWdata;
                `PIB_OFS_ROMCTL:  romCtl  <= cfgWdata;
                `PIB_OFS_DECCTL2: decCtl2 <= cfgWdata & `PIB_MASK_DECCTL2;
                default: ;
            endcase
        end
    end

    // Read mux, registered; reset control is write-only so reads zero
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n)
            cfgRdata <= 8'h00;
        else if (cfgRead) begin
            case (cfgAddr)
                `PIB_OFS_FC2:     cfgRdata <= fc2;
                `PIB_OFS_FC3:     cfgRdata <= fc3;
                `PIB_OFS_FC4:     cfgRdata <= fc4;
                `PIB_OFS_ISACLK:  cfgRdata <= isaDiv;
                `PIB_OFS_IOREC:   cfgRdata <= ioRec;
                `PIB_OFS_ROMCTL:  cfgRdata <= romCtl;
                `PIB_OFS_DECCTL2: cfgRdata <= decCtl2;
                default:          cfgRdata <= 8'h00;
            endcase
        end
    end

    // Warm start: a write of one fires a fixed-length reset pulse
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            warmCnt   <= 4'h0;
            warmReset <= 1'b0;
        end else begin
            if (cfgWrite && cfgAddr == `PIB_OFS_RSTCTL
                && cfgWdata[`PIB_BIT_WARM])
                warmCnt <= `PIB_WARM_CYCLES;
            else if (warmCnt != 4'h0)
                warmCnt <= warmCnt - 4'h1;
            warmReset <= (warmCnt != 4'h0);
        end
    end

    // Mode outputs registered from config bits; retry, ROM claim and SERR enable also gated by inputs
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            wbufEn    <= 1'b0;
            delayedEn <= 1'b0;
            noArbBuf  <= 1'b0;
            retryReq  <= 1'b0;
            romClaim  <= 1'b0;
            serrOut_n <= 1'b1;
            serrOe    <= 1'b0;
        end else begin
            wbufEn    <= fc2[`PIB_BIT_WBUF];
            delayedEn <= fc3[`PIB_BIT_DELAYED];
            noArbBuf  <= fc3[`PIB_BIT_NOARB];
            // Retry is meaningless without delayed transactions
            retryReq  <= bufFull && fc4[`PIB_BIT_RETRY]
                         && fc3[`PIB_BIT_DELAYED];
            romClaim  <= romHit && decCtl2[`PIB_BIT_ROMCLAIM];
            // SERR is open drain: only ever pulled low
            serrOe    <= fc2[`PIB_BIT_PERR_SERR]
                         && (perrDriven || !perrS_n);
            serrOut_n <= 1'b0;
        end
    end

    // Sample point; code 1x keeps the tracker idle
    assign samplePoint = fc2[`PIB_BIT_SUBD_LO] ? `PIB_SAMPLE_EARLY
                                               : `PIB_SAMPLE_DEFAULT;

    // Subtractive claim tracker; synchroniser delay shifts the count,
    // so this is a decision strobe, not a bus-accurate DEVSEL
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            frameLast_n <= 1'b1;
            frameClk    <= 3'h0;
            tracking    <= 1'b0;
            devClaimed  <= 1'b0;
            subClaim    <= 1'b0;
        end else begin
            frameLast_n <= frameS_n;
            subClaim    <= 1'b0;
            if (frameLast_n && !frameS_n
                && !fc2[`PIB_BIT_SUBD_HI]) begin
                tracking   <= 1'b1;
                frameClk   <= 3'h1;
                devClaimed <= !devS_n || romClaim;
            end else if (tracking) begin
                frameClk   <= frameClk + 3'h1;
                devClaimed <= devClaimed || !devS_n;
                if (frameClk == samplePoint) begin
                    tracking <= 1'b0;
                    subClaim <= !(devClaimed || !devS_n);
                end
            end
        end
    end

    // ISA clock and recovery spacing
    pib_isa_timing timing (
        .clk_sys    (clk_sys),
        .rstSync_n  (rstSync_n),
        .clkDivCode (isaDiv[2:0]),
        .rec8       (ioRec[7:4]),
        .rec16      (ioRec[3:0]),
        .ioDone     (ioDone),
        .ioIs16     (ioIs16),
        .isaClk     (isaClkInt),
        .ioHold     (ioHoldInt)
    );

    // Re-register so top outputs come from flops here
    always @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
            isaClk <= 1'b0;
            ioHold <= 1'b0;
        end else begin
            isaClk <= isaClkInt;
            ioHold <= ioHoldInt;
        end
    end
endmodule

/* sim/pib_config_regs_sva.sv */
`timescale 1ns/100ps
module pib_cfg_chk (
    input wire clk_sys,
    input wire rst_n,
    input wire bufFull,
    input wire devselSeen_n,
    input wire perrSeen_n,
    input wire perrDriven,
    input wire ioDone,
    input wire serrOe,
    input wire subClaim,
    input wire retryReq,
    input wire delayedEn,
    input wire warmReset,
    input wire isaClk,
    input wire ioHold
);
    // One domain, so one clock and one reset for every property
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    chk_retry_gate: assert property (
        retryReq |-> delayedEn || $past(delayedEn)) else $error("retry gate");
    chk_retry_cause: assert property (
        retryReq |-> $past(bufFull)) else $error("retry without full buffer");
    chk_sub_pulse: assert property (
        subClaim |=> !subClaim) else $error("claim pulse too long");
    chk_sub_devsel: assert property (
        !devselSeen_n [*8] |=> !subClaim) else $error("claim under devsel");
    chk_warm_len: assert property (
        $rose(warmReset) |-> warmReset [*8] ##1 warmReset [*7] ##1 !warmReset)
        else $error("warm pulse length");
    chk_serr_cause: assert property (
        (!perrDriven && perrSeen_n) [*6] |=> !serrOe) else $error("stray serr");
    chk_hold_cause: assert property (
        $rose(ioHold) |-> $past(ioDone) || $past(ioDone, 2) || $past(ioDone, 3))
        else $error("recovery without io end");
    chk_isa_period: assert property (
        $rose(isaClk) |-> ##[3:4] $rose(isaClk)) else $error("isa period");
endmodule
bind pib_config_regs pib_cfg_chk i_pib_cfg_chk (.clk_sys, .rst_n, .bufFull,
    .devselSeen_n, .perrSeen_n, .perrDriven, .ioDone, .serrOe, .subClaim,
    .retryReq, .delayedEn, .warmReset, .isaClk, .ioHold);

/* sim/pib_host_model.sv */
`timescale 1ns/100ps
module pib_host_model (
    input  wire       clk_sys,
    output reg        cfgWrite,
    output reg        cfgRead,
    output reg  [7:0] cfgAddr,
    output reg  [7:0] cfgWdata,
    input  wire [7:0] cfgRdata
);
    // Idle bus with both strobes low
    initial {cfgWrite, cfgRead, cfgAddr, cfgWdata} = 18'h0;
    // Write held for one edge; released data is scrambled, not kept
    task wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge clk_sys) #1 {cfgWrite, cfgAddr, cfgWdata} = {1'b1, a, v};
            @(posedge clk_sys) #1 {cfgWrite, cfgAddr, cfgWdata} = {1'b0, ~a, ~v};
        end
    endtask
    // Answer stands until next read, so sampling an edge late is safe
    task rd(input [7:0] a, output [7:0] v);
        begin
            @(posedge clk_sys) #1 {cfgRead, cfgAddr} = {1'b1, a};
            @(posedge clk_sys) #1 {cfgRead, cfgAddr} = {1'b0, ~a};
            @(posedge clk_sys) #1 v = cfgRdata;
        end
    endtask
endmodule

/* sim/pib_config_regs_bench.sv */
`timescale 1ns/100ps
module pib_config_regs_bench;
    reg clk_sys = 0, rst_n = 0, frameStart_n = 1, devselSeen_n = 1, romHit = 0;
    reg perrSeen_n = 1, perrDriven = 0, bufFull = 0, ioDone = 0, ioIs16 = 0;
    wire cfgWrite, cfgRead, serrOut_n, serrOe, subClaim, romClaim, wbufEn;
    wire delayedEn, noArbBuf, retryReq, warmReset, isaClk, ioHold;
    wire [7:0] cfgAddr, cfgWdata, cfgRdata;
    wire [2:0] obs = {ioHold, warmReset, serrOe};
    integer error_cnt = 0, comparisons = 0, cyc = 0, p, q, r;
    reg [7:0] d;
    always #50 clk_sys = ~clk_sys;
    pib_host_model i_pib_host_model (.clk_sys, .cfgWrite, .cfgRead, .cfgAddr,
        .cfgWdata, .cfgRdata);
    pib_config_regs i_pib_config_regs (.clk_sys, .rst_n, .cfgWrite, .cfgRead,
        .cfgAddr, .cfgWdata, .cfgRdata, .frameStart_n, .devselSeen_n, .romHit,
        .perrSeen_n, .perrDriven, .bufFull, .ioDone, .ioIs16, .serrOut_n,
        .serrOe, .subClaim, .romClaim, .wbufEn, .delayedEn, .noArbBuf,
        .retryReq, .warmReset, .isaClk, .ioHold);
    task chk(input string nm, input [7:0] e, input [7:0] g);
        begin
            comparisons++;
            if (g !== e) begin
                error_cnt++;
                $display("wrong value %0s exp %h got %h", nm, e, g);
            end
        end
    endtask
    task stop_test;
        begin
            $display("comparisons %0d errors %0d", comparisons, error_cnt);
            if (error_cnt == 0 && comparisons > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // Drive just after an edge so nothing races the sampling edge
    task tk(input integer n); begin repeat (n) @(posedge clk_sys); #1; end
    endtask
    task wr(input [7:0] a, v); i_pib_host_model.wr(a, v); endtask
    task rc(input [7:0] a, e);
        begin i_pib_host_model.rd(a, d); chk($sformatf("reg %h", a), e, d); end
    endtask
    // Counts high cycles of one observed output over a window
    task cnt(input integer k, n, output integer c);
        begin c = 0; repeat (n) begin tk(1); if (obs[k] === 1'b1) c++; end end
    endtask
    task t_regs;
        begin
            rc(8'h42, 8'h28); rc(8'h43, 8'h46); rc(8'h50, 8'h43);
            rc(8'h51, 8'h43); rc(8'h52, 8'h04); rc(8'h5B, 8'h00);
            rc(8'h60, 8'h00); wr(8'h60, 8'hAA); rc(8'h60, 8'h00);
            // Software keeps internal bits as read, reserved bits zero
            wr(8'h43, 8'h44); rc(8'h43, 8'h44); wr(8'h43, 8'h46);
            wr(8'h5B, 8'h20); rc(8'h5B, 8'h20); wr(8'h5B, 8'h00);
            chk("delayed", 1, delayedEn);
            chk("noarb", 1, noArbBuf);
            wr(8'h41, 8'h00); wr(8'h42, 8'h00); tk(3);
            chk("wbuf", 0, wbufEn);
            chk("delayed", 0, delayedEn);
            chk("noarb", 0, noArbBuf);
            wr(8'h41, 8'h10); wr(8'h42, 8'h28); tk(3);
            chk("wbuf", 1, wbufEn);
            $display("registers done");
        end
    endtask
    task t_warm;
        begin
            wr(8'h44, 8'h01); cnt(1, 30, p);
            chk("warm len", 15, p);
            rc(8'h44, 8'h00); wr(8'h44, 8'h00); cnt(1, 30, p);
            chk("warm nop", 0, p);
            $display("warm start done");
        end
    endtask
    // Perr held while counting, enable bit written first
    task perr(input [7:0] en, input dr, input [7:0] e);
        begin
            wr(8'h41, en); perrDriven = dr; perrSeen_n = dr;
            cnt(0, 6, p); perrDriven = 0; perrSeen_n = 1; tk(6);
            chk("serr", e, p > 0);
        end
    endtask
    task t_serr;
        begin
            perr(8'h30, 1, 1); perr(8'h30, 0, 1); perr(8'h10, 1, 0);
            perr(8'h10, 0, 0);
            // Open-drain data level stays low once running
            chk("serr level", 0, serrOut_n);
            $display("parity done");
        end
    endtask
    task t_retry;
        begin
            bufFull = 1; tk(3);
            chk("retry", 1, retryReq);
            wr(8'h42, 8'h08); tk(3);
            chk("retry", 0, retryReq);
            wr(8'h42, 8'h28); wr(8'h43, 8'h44); tk(3);
            chk("retry", 0, retryReq);
            wr(8'h43, 8'h46); bufFull = 0; tk(3);
            chk("retry", 0, retryReq);
            $display("retry done");
        end
    endtask
    // Period taken from first and last rising edge in a window
    task isa(input [7:0] code, per);
        integer f, l, k;
        reg o;
        begin
            wr(8'h50, code); tk(8); f = 0; l = 0; k = 0; o = 1;
            for (int i = 1; i <= 30; i++) begin
                tk(1);
                if (isaClk && !o) begin if (k == 0) f = i; l = i; k++; end
                o = isaClk;
            end
            chk("isa period", per, (l - f) / (k - 1));
        end
    endtask
    task t_isa; begin isa(8'h42, 3); isa(8'h43, 4); $display("isa done"); end
    endtask
    // One frame; returns cycle of first subtractive claim, 0 if none
    task frame(input [7:0] c, input dv, rm, output integer at);
        begin
            wr(8'h41, c); at = 0; r = 0;
            frameStart_n = 0; devselSeen_n = !dv; romHit = rm;
            for (int i = 1; i <= 12; i++) begin
                tk(1);
                if (subClaim === 1'b1 && at == 0) at = i;
                if (romClaim === 1'b1) r = 1;
            end
            frameStart_n = 1; devselSeen_n = 1; romHit = 0; tk(6);
        end
    endtask
    task t_sub;
        begin
            frame(8'h10, 0, 0, p);
            // Early sample only because no slow agent sits on this bus
            frame(8'h12, 0, 0, q);
            chk("sample gap", 1, p - q);
            frame(8'h14, 0, 0, p); frame(8'h16, 0, 0, q);
            chk("sub off", 0, p + q);
            frame(8'h10, 1, 0, p);
            chk("sub devsel", 0, p);
            wr(8'h5B, 8'h20); frame(8'h10, 0, 1, p);
            chk("rom claim", 1, r);
            chk("rom no sub", 0, p);
            wr(8'h5B, 8'h00); frame(8'h10, 0, 1, p);
            chk("rom sub", 0, r | (p == 0));
            $display("decode done");
        end
    endtask
    task hold(input s, output integer w);
        begin
            ioIs16 = s; ioDone = 1; tk(1); ioDone = 0; cnt(2, 40, w); ioIs16 = 0;
        end
    endtask
    task t_rec;
        begin
            // Gap is code plus one, plus the built-in clock
            wr(8'h51, 8'h50); hold(0, p); hold(1, q);
            chk("rec8", 5, p - q);
            chk("rec8 len", 7, p);
            chk("rec16 min", 2, q);
            wr(8'h51, 8'h0F); hold(0, p); hold(1, q);
            chk("rec16", 15, q - p);
            chk("rec16 max", 17, q);
            $display("recovery done");
        end
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 8000) begin error_cnt++; stop_test; end
    end
    initial begin
        tk(8); rst_n = 1; tk(3);
        t_regs; t_warm; t_serr; t_retry; t_isa; t_sub; t_rec;
        stop_test;
    end
endmodule
